// ### sscf_front_end.sv
// Purpose: Slave serial command front end (single/dual/quad, quad and octal lane modes)
// Assumes: Serial clock slower than clk_in/2 by sampling; bench link 5 MHz
// Notes:   Requests leave through a two-entry buffer; read words come back on rdata
// Functional notes
// - Four-wire and six-wire pin arrangements supported
// - Serial clock limits 100 or 80 MHz
// - Output variants serial address; I/O wide address
// - Capture input bits on rising clock
// - Launch output bits on falling clock
// - Either clock idle polarity works
// - Select high ignores inputs, releases outputs
// - Instruction eight bits on lane zero in single mode, on four or eight lanes in quad or octal mode
// - Two address bytes, one/two/four/eight bits per clock
// - Address is byte address, word access
// - Address bits 15:14 pick step direction
// - FIFO addresses never step
// - Dummy cycles after address, outputs undriven
// - Data follows as 32-bit words
// - Enter-quad instruction selects four lanes from single mode
// - Enter-octal instruction selects eight lanes from single mode
// - Most significant group shifted first
// - Address MSB first, data little endian
// - Opcodes 38h, 3Ah, FFh configure lanes
// - Reset instruction restores single lane anywhere
// - Further words follow by continued clocking
// - Read dummy bytes one, three, eight by lane mode; two and four for single-mode I/O reads
`timescale 1ns/1ps
`default_nettype none
`include "sscf_map.svh"
module sscf_front_end #(
  parameter logic [15:0] FIFO_ADDR_MASK = 16'h3F00,
  parameter logic [15:0] FIFO_ADDR_BASE = 16'h3000
) (
  input  wire logic               clk_in,
  input  wire logic               resetn_in,
  input  wire logic               sck_in,
  input  wire logic               csn_in,
  input  wire logic [7:0]         lane_in,
  output logic      [7:0]         lane_out,
  output logic      [7:0]         lane_oe_out,
  output logic                    req_valid_out,
  input  wire logic               req_ready_in,
  output sscf_pkg::sscf_req_t     req_out,
  input  wire logic               rdata_valid_in,
  input  wire logic [31:0]        rdata_in,
  output logic                    rdata_ready_out,
  output sscf_pkg::sscf_lane_t    lane_mode_out
);
  // Two-flop synchronisers on every pin; they cap the link clock well below clk_in
  logic [9:0] sync1_reg;
  logic [9:0] sync2_reg;
  logic       sck_d_reg;
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      sync1_reg <= 10'h200;
      sync2_reg <= 10'h200;
      sck_d_reg <= 1'b0;
    end else begin
      sync1_reg <= {csn_in, sck_in, lane_in};
      sync2_reg <= sync1_reg;
      sck_d_reg <= sync2_reg[8];
    end
  end
  logic       cs_act;
  logic       sck_rise;
  logic       sck_fall;
  logic [7:0] din;
  // Edges only count inside a frame, so idle level of the clock is irrelevant
  assign cs_act   = ~sync2_reg[9];
  assign sck_rise = cs_act & sync2_reg[8] & ~sck_d_reg;
  assign sck_fall = cs_act & ~sync2_reg[8] & sck_d_reg;
  assign din      = sync2_reg[7:0];

  sscf_pkg::sscf_state_t st_reg, st_next;
  sscf_pkg::sscf_lane_t  mode_reg, mode_next;
  logic [7:0]  cmd_reg, cmd_next;
  logic [15:0] addr_reg, addr_next;
  logic [31:0] sh_reg, sh_next;
  logic [5:0]  bits_reg, bits_next;
  logic [3:0]  dum_reg, dum_next;
  logic [3:0]  width_reg, width_next;      // Data lanes per clock
  logic [3:0]  awidth_reg, awidth_next;    // Address/dummy lanes per clock
  logic [31:0] tx_reg, tx_next;
  logic [7:0]  out_reg, out_next;
  logic        oe_reg, oe_next;
  logic        txv_reg, txv_next;          // Read word loaded
  logic        rdreq_reg, rdreq_next;      // Read request pending
  logic        wr_push, rd_push;
  logic        buf_ready;
  logic        fifo_hit;
  logic [15:0] step_addr;
  logic [5:0]  in_w;
  logic [3:0]  cur_w;
  logic [7:0]  dmask;
  logic [31:0] le_word;

  assign fifo_hit = (addr_reg & FIFO_ADDR_MASK) == FIFO_ADDR_BASE;
  assign lane_mode_out = mode_reg;

  // Next address after one word; byte address moves by four
  always_comb begin
    step_addr = addr_reg;
    if (!fifo_hit) begin
      if (addr_reg[`SSCF_STEP_MSB:`SSCF_STEP_LSB] == `SSCF_STEP_DEC) begin
        step_addr = addr_reg - `SSCF_WORD_BYTES;
      end else if (addr_reg[`SSCF_STEP_MSB:`SSCF_STEP_LSB] == `SSCF_STEP_INC) begin
        step_addr = addr_reg + `SSCF_WORD_BYTES;
      end
    end
  end

  // Lanes used in the current phase
  always_comb begin
    case (st_reg)
      sscf_pkg::SSCF_ST_CMD: cur_w = (mode_reg == sscf_pkg::SSCF_LANE_QUAD) ? 4'h4 :
                                     (mode_reg == sscf_pkg::SSCF_LANE_OCT) ? 4'h8 : 4'h1;
      sscf_pkg::SSCF_ST_ADDR,
      sscf_pkg::SSCF_ST_DUMMY: cur_w = awidth_reg;
      default: cur_w = width_reg;
    endcase
    dmask = 8'hFF >> (4'h8 - cur_w);
    in_w  = {2'h0, cur_w};
  end

  // Pushed word includes the group taken on the pushing edge; little endian
  assign le_word = {sh_next[7:0], sh_next[15:8], sh_next[23:16], sh_next[31:24]};

  // Frame state machine
  always_comb begin
    st_next     = st_reg;
    mode_next   = mode_reg;
    cmd_next    = cmd_reg;
    addr_next   = addr_reg;
    sh_next     = sh_reg;
    bits_next   = bits_reg;
    dum_next    = dum_reg;
    width_next  = width_reg;
    awidth_next = awidth_reg;
    tx_next     = tx_reg;
    out_next    = out_reg;
    oe_next     = oe_reg;
    txv_next    = txv_reg;
    rdreq_next  = rdreq_reg;
    wr_push     = 1'b0;
    rd_push     = 1'b0;
    if (!cs_act) begin
      // Abandon partial frame, keep lane mode
      st_next    = sscf_pkg::SSCF_ST_CMD;
      bits_next  = 6'h00;
      oe_next    = 1'b0;
      txv_next   = 1'b0;
      rdreq_next = 1'b0;
    end else if (sck_rise) begin
      sh_next   = (sh_reg << in_w) | {24'h0, din & dmask};
      bits_next = bits_reg + in_w;
      case (st_reg)
        sscf_pkg::SSCF_ST_CMD: begin
          if (bits_reg + in_w == 6'h08) begin
            bits_next = 6'h00;
            cmd_next  = sh_next[7:0];
            st_next   = sscf_pkg::SSCF_ST_ADDR;
            width_next  = cur_w;
            awidth_next = cur_w;
            dum_next    = (mode_reg == sscf_pkg::SSCF_LANE_QUAD) ? `SSCF_DUMMY_QUAD :
                          (mode_reg == sscf_pkg::SSCF_LANE_OCT) ? `SSCF_DUMMY_OCT :
                          `SSCF_DUMMY_SINGLE;
            if (mode_reg == sscf_pkg::SSCF_LANE_SINGLE) begin
              case (sh_next[7:0])
                `SSCF_OP_DOREAD2, `SSCF_OP_DWRITE2: width_next = 4'h2;
                `SSCF_OP_DOREAD4, `SSCF_OP_DWRITE4: width_next = 4'h4;
                `SSCF_OP_IOREAD2, `SSCF_OP_AWRITE2: begin
                  width_next  = 4'h2;
                  awidth_next = 4'h2;
                end
                `SSCF_OP_IOREAD4, `SSCF_OP_AWRITE4: begin
                  width_next  = 4'h4;
                  awidth_next = 4'h4;
                end
                default: width_next = 4'h1;
              endcase
              if (sh_next[7:0] == `SSCF_OP_IOREAD2) dum_next = `SSCF_DUMMY_DUAL_IO;
              if (sh_next[7:0] == `SSCF_OP_IOREAD4) dum_next = `SSCF_DUMMY_QUAD_IO;
            end
            case (sh_next[7:0])
              `SSCF_OP_ENTER_QUAD: begin
                st_next = sscf_pkg::SSCF_ST_DONE;
                if (mode_reg == sscf_pkg::SSCF_LANE_SINGLE)
                  mode_next = sscf_pkg::SSCF_LANE_QUAD;
              end
              `SSCF_OP_ENTER_OCT: begin
                st_next = sscf_pkg::SSCF_ST_DONE;
                if (mode_reg == sscf_pkg::SSCF_LANE_SINGLE)
                  mode_next = sscf_pkg::SSCF_LANE_OCT;
              end
              `SSCF_OP_EXIT_WIDE: begin
                st_next   = sscf_pkg::SSCF_ST_DONE;
                mode_next = sscf_pkg::SSCF_LANE_SINGLE;
              end
              `SSCF_OP_READ, `SSCF_OP_DOREAD2, `SSCF_OP_IOREAD2, `SSCF_OP_DOREAD4,
              `SSCF_OP_IOREAD4, `SSCF_OP_WRITE, `SSCF_OP_DWRITE2, `SSCF_OP_AWRITE2,
              `SSCF_OP_DWRITE4, `SSCF_OP_AWRITE4: st_next = sscf_pkg::SSCF_ST_ADDR;
              default: st_next = sscf_pkg::SSCF_ST_DONE;
            endcase
          end
        end
        sscf_pkg::SSCF_ST_ADDR: begin
          if (bits_reg + in_w == 6'h10) begin
            bits_next = 6'h00;
            addr_next = sh_next[15:0];
            if (cmd_reg == `SSCF_OP_WRITE || cmd_reg == `SSCF_OP_DWRITE2 ||
                cmd_reg == `SSCF_OP_AWRITE2 || cmd_reg == `SSCF_OP_DWRITE4 ||
                cmd_reg == `SSCF_OP_AWRITE4) begin
              st_next = sscf_pkg::SSCF_ST_WDATA;
            end else begin
              st_next    = sscf_pkg::SSCF_ST_DUMMY;
              rdreq_next = 1'b1;                            // Fetch during dummy
            end
          end
        end
        sscf_pkg::SSCF_ST_DUMMY: begin
          oe_next = 1'b0;
          if (bits_reg + in_w == 6'h08) begin
            bits_next = 6'h00;
            dum_next  = dum_reg - 4'h1;
            if (dum_reg == 4'h1) st_next = sscf_pkg::SSCF_ST_RDATA;
          end
        end
        sscf_pkg::SSCF_ST_WDATA: begin
          if (bits_reg + in_w == 6'h20) begin
            bits_next = 6'h00;
            wr_push   = 1'b1;
            addr_next = step_addr;
          end
        end
        sscf_pkg::SSCF_ST_RDATA: begin
          if (bits_reg + in_w == 6'h20) begin
            bits_next  = 6'h00;
            addr_next  = step_addr;
            txv_next   = 1'b0;
            rdreq_next = 1'b1;
          end
        end
        default: bits_next = 6'h00;
      endcase
    end else if (sck_fall && st_reg == sscf_pkg::SSCF_ST_RDATA) begin
      // Shift out msb first, low byte first; lanes above width stay released
      out_next = 8'h00;
      for (int i = 0; i < 8; i++) begin
        if (i < int'(width_reg)) out_next[i] = tx_reg[31 - int'(width_reg) + 1 + i];
      end
      if (width_reg == 4'h1) out_next = {6'h00, tx_reg[31], 1'b0}; // Single lane drives lane 1
      tx_next = tx_reg << width_reg;
      oe_next = 1'b1;
    end
    // Pending read goes to buffer, answer loads transmit word
    if (cs_act && rdreq_reg && buf_ready && !wr_push) begin
      rd_push    = 1'b1;
      rdreq_next = 1'b0;
    end
    if (cs_act && rdata_valid_in && !txv_reg) begin
      tx_next  = {rdata_in[7:0], rdata_in[15:8], rdata_in[23:16], rdata_in[31:24]};
      txv_next = 1'b1;
    end
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      st_reg     <= sscf_pkg::SSCF_ST_CMD;
      mode_reg   <= sscf_pkg::SSCF_LANE_SINGLE;
      cmd_reg    <= 8'h00;
      addr_reg   <= 16'h0000;
      sh_reg     <= 32'h0000_0000;
      bits_reg   <= 6'h00;
      dum_reg    <= 4'h0;
      width_reg  <= 4'h1;
      awidth_reg <= 4'h1;
      tx_reg     <= 32'h0000_0000;
      out_reg    <= 8'h00;
      oe_reg     <= 1'b0;
      txv_reg    <= 1'b0;
      rdreq_reg  <= 1'b0;
    end else begin
      st_reg     <= st_next;
      mode_reg   <= mode_next;
      cmd_reg    <= cmd_next;
      addr_reg   <= addr_next;
      sh_reg     <= sh_next;
      bits_reg   <= bits_next;
      dum_reg    <= dum_next;
      width_reg  <= width_next;
      awidth_reg <= awidth_next;
      tx_reg     <= tx_next;
      out_reg    <= out_next;
      oe_reg     <= oe_next;
      txv_reg    <= txv_next;
      rdreq_reg  <= rdreq_next;
    end
  end

  // Output lanes; a lane drives only while selected and in the read data phase
  always_comb begin
    lane_out    = out_reg;
    lane_oe_out = 8'h00;
    for (int i = 0; i < 8; i++) begin
      if (i < int'(width_reg)) lane_oe_out[i] = oe_reg & cs_act;
    end
    if (width_reg == 4'h1) lane_oe_out = {6'h00, oe_reg & cs_act, 1'b0};
  end
  assign rdata_ready_out = cs_act & ~txv_reg;

  // Two-entry request buffer; a write pushed while full is lost, so
  // the back end must drain faster than one word per 32 serial clocks on one lane, per 4 on eight lanes
  sscf_pkg::sscf_req_t buf_mem [2];
  logic [1:0] cnt_reg, cnt_next;
  logic       wp_reg, wp_next, rp_reg, rp_next;
  logic       push;
  logic       pop;
  sscf_pkg::sscf_req_t push_data;
  assign buf_ready = cnt_reg != 2'h2;
  assign push      = (wr_push | rd_push) & buf_ready;
  assign pop       = req_valid_out & req_ready_in;
  assign push_data = '{addr: addr_reg, write: wr_push, data: le_word};
  assign req_valid_out = cnt_reg != 2'h0;
  assign req_out   = buf_mem[rp_reg];
  always_comb begin
    wp_next  = push ? ~wp_reg : wp_reg;
    rp_next  = pop ? ~rp_reg : rp_reg;
    cnt_next = cnt_reg + {1'b0, push} - {1'b0, pop};
  end
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      cnt_reg    <= 2'h0;
      wp_reg     <= 1'b0;
      rp_reg     <= 1'b0;
      buf_mem[0] <= '0;
      buf_mem[1] <= '0;
    end else begin
      cnt_reg <= cnt_next;
      wp_reg  <= wp_next;
      rp_reg  <= rp_next;
      if (push) buf_mem[wp_reg] <= push_data;
    end
  end
endmodule
`default_nettype wire

// ### sscf_map.svh
// Purpose: Constants for the serial slave command front end
// Assumes: Included by bare name
// Notes:   Opcodes, phase lengths and address field positions
`ifndef SSCF_MAP_SVH
`define SSCF_MAP_SVH
`define SSCF_OP_READ      8'h0B
`define SSCF_OP_DOREAD2   8'h3B
`define SSCF_OP_IOREAD2   8'hBB
`define SSCF_OP_DOREAD4   8'h6B
`define SSCF_OP_IOREAD4   8'hEB
`define SSCF_OP_WRITE     8'h02
`define SSCF_OP_DWRITE2   8'h32
`define SSCF_OP_AWRITE2   8'hB2
`define SSCF_OP_DWRITE4   8'h62
`define SSCF_OP_AWRITE4   8'hE2
`define SSCF_OP_ENTER_QUAD 8'h38
`define SSCF_OP_ENTER_OCT 8'h3A
`define SSCF_OP_EXIT_WIDE 8'hFF
`define SSCF_DUMMY_SINGLE 4'h1
`define SSCF_DUMMY_QUAD   4'h3
`define SSCF_DUMMY_OCT    4'h8
`define SSCF_DUMMY_DUAL_IO 4'h2
`define SSCF_DUMMY_QUAD_IO 4'h4
`define SSCF_STEP_MSB     15
`define SSCF_STEP_LSB     14
`define SSCF_STEP_DEC     2'h2
`define SSCF_STEP_INC     2'h1
`define SSCF_WORD_BYTES   16'h0004
`endif

// ### sscf_pkg.sv
// Purpose: Types for the serial slave command front end
// Assumes: Nothing
// Notes:   Constants live in sscf_map.svh
package sscf_pkg;
  typedef enum logic [1:0] {
    SSCF_LANE_SINGLE = 2'b00,
    SSCF_LANE_QUAD   = 2'b01,
    SSCF_LANE_OCT    = 2'b10
  } sscf_lane_t;
  typedef enum logic [2:0] {
    SSCF_ST_CMD   = 3'b000,
    SSCF_ST_ADDR  = 3'b001,
    SSCF_ST_DUMMY = 3'b010,
    SSCF_ST_RDATA = 3'b011,
    SSCF_ST_WDATA = 3'b100,
    SSCF_ST_DONE  = 3'b101
  } sscf_state_t;
  typedef struct packed {
    logic [15:0] addr;
    logic        write;
    logic [31:0] data;
  } sscf_req_t;
endpackage

// ### sscf_checker.sv
// Purpose: Port-level checks of the serial command front end
// Assumes: Bound to every sscf_front_end instance
// Notes:   Select is synchronised, so release is judged after 8 clocks
`timescale 1ns/1ps
`default_nettype none
module sscf_checker (
  input wire logic                 clk_in,
  input wire logic                 resetn_in,
  input wire logic                 csn_in,
  input wire logic [7:0]           lane_out,
  input wire logic [7:0]           lane_oe_out,
  input wire logic                 req_valid_out,
  input wire logic                 req_ready_in,
  input wire sscf_pkg::sscf_req_t  req_out,
  input wire logic                 rdata_ready_out,
  input wire sscf_pkg::sscf_lane_t lane_mode_out
);
  logic is_single;
  logic is_quad;
  // Mode decodes keep the properties short
  assign is_single = lane_mode_out == sscf_pkg::SSCF_LANE_SINGLE;
  assign is_quad   = lane_mode_out == sscf_pkg::SSCF_LANE_QUAD;
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!resetn_in);
  // Deselected device drives nothing and takes no read word
  idle_release_a: assert property (csn_in [*8] |-> lane_oe_out == 8'h00)
    else $error("lanes driven while deselected");
  idle_ready_a: assert property (csn_in [*8] |-> !rdata_ready_out)
    else $error("read word taken while deselected");
  oe_select_a: assert property ($rose(|lane_oe_out) |-> !csn_in)
    else $error("lanes driven without select");
  // Lane use per mode
  single_width_a: assert property (is_single |-> lane_oe_out[7:4] == 4'h0)
    else $error("upper lanes driven in single mode");
  quad_width_a: assert property (is_quad |-> lane_oe_out[7:4] == 4'h0)
    else $error("upper lanes driven in quad mode");
  mode_path_a: assert property ($changed(lane_mode_out) |-> $past(is_single) || is_single)
    else $error("wide mode changed without single step");
  // One launch per serial period, so a driven value holds for several clocks
  out_hold_a: assert property ($changed(lane_out) && lane_oe_out != 8'h00
    |=> ($stable(lane_out) || lane_oe_out == 8'h00) [*5])
    else $error("lane data changed too soon");
  req_hold_a: assert property (req_valid_out && !req_ready_in |=> req_valid_out && $stable(req_out))
    else $error("stalled request lost");
  reset_clear_a: assert property ($rose(resetn_in) |-> lane_oe_out == 8'h00 && is_single)
    else $error("outputs not cleared by reset");
  cover property (req_valid_out && req_ready_in && req_out.write);
  cover property ($rose(|lane_oe_out));
  cover property (lane_mode_out == sscf_pkg::SSCF_LANE_OCT);
endmodule
bind sscf_front_end sscf_checker chk (.clk_in, .resetn_in, .csn_in, .lane_out, .lane_oe_out,
  .req_valid_out, .req_ready_in, .req_out, .rdata_ready_out, .lane_mode_out);
`default_nettype wire

// ### sscf_host_model.sv
// Purpose: Serial master model for the front end's lanes
// Assumes: Link period 200 ns, unrelated to the system clock
// Notes:   Released lanes show the inverse of their last level
`timescale 1ns/1ps
`default_nettype none
module sscf_host_model (
  input  wire logic [7:0] dev_data_in,
  input  wire logic [7:0] dev_oe_in,
  output logic            sck_out,
  output logic            csn_out,
  output logic      [7:0] lane_out
);
  logic [7:0] hv = 8'h00;
  logic [7:0] ho = 8'h00;
  logic       cpol = 1'b0;
  int         clash = 0;
  initial begin
    sck_out = 1'b0;
    csn_out = 1'b1;
  end
  // Wire level; single reads come back on lane 1, the rest share lanes
  always_comb
    for (int i = 0; i < 8; i++)
      lane_out[i] = dev_oe_in[i] ? dev_data_in[i] : (ho[i] ? hv[i] : ~hv[i]);
  // Two drivers on one lane means the device drove out of turn
  always @(dev_oe_in or ho)
    if ((dev_oe_in & ho) != 8'h00) clash++;
  task automatic begin_frame();
    sck_out = cpol;
    #60 csn_out = 1'b0;
    #100 sck_out = 1'b0; // Idle-high clock opens with a dead fall
  endtask
  // Data set while the clock is low, top group first; 5 MHz link
  task automatic shift_in(input logic [31:0] val, input int nbits, input int w, input logic [7:0] en);
    ho = en;
    for (int i = nbits - w; i >= 0; i -= w) begin
      hv = 8'((val >> i) & ((32'h1 << w) - 32'h1));
      #100 sck_out = 1'b1;
      #100 sck_out = 1'b0;
    end
  endtask
  // Sampled mid high phase, clear of the device's launch delay
  task automatic shift_out(output logic [7:0] val, input int w);
    val = 8'h00;
    ho = 8'h00;
    for (int i = 0; i < 8; i += w) begin
      #100 sck_out = 1'b1;
      #50 val = 8'((val << w) | (w == 1 ? {7'h0, lane_out[1]} : lane_out & 8'((9'h1 << w) - 9'h1)));
      #50 sck_out = 1'b0;
    end
  endtask
  task automatic end_frame();
    #100 sck_out = cpol;
    #100 csn_out = 1'b1; // High for 160 ns or more before the next frame
    ho = 8'h00;
    #100;
  endtask
  // Clock and lane activity with select high
  task automatic noise(input int n);
    ho = 8'hFF;
    repeat (n) #100 begin
      hv = ~hv;
      sck_out = ~sck_out;
    end
    ho = 8'h00;
  endtask
endmodule
`default_nettype wire

// ### sscf_front_end_tb.sv
// Purpose: Self-checking bench for the serial command front end
// Assumes: Host model drives the link, bench plays the back end
// Notes: Only defined opcodes are sent, bursts at 5 MHz
`timescale 1ns/1ps
`default_nettype none
`include "sscf_map.svh"
module sscf_front_end_tb;
  localparam logic [15:0] FM = 16'h3F00;
  localparam logic [15:0] FB = 16'h3000;
  logic                 clk_in = 1'b0;
  logic                 resetn_in = 1'b0;
  logic                 sck;
  logic                 csn;
  logic [7:0]           lane;
  logic [7:0]           lane_out;
  logic [7:0]           lane_oe;
  logic                 req_valid;
  logic                 req_ready = 1'b0;
  sscf_pkg::sscf_req_t  req;
  logic                 rdata_valid = 1'b0;
  logic [31:0]          rdata = 32'h0;
  logic                 rdata_ready;
  sscf_pkg::sscf_lane_t lane_mode;
  logic                 stall = 1'b0;
  int                   miscompares = 0;
  int                   checks = 0;
  sscf_pkg::sscf_req_t  popped[$];
  always #12.5 clk_in = ~clk_in;
  sscf_front_end #(.FIFO_ADDR_MASK(FM), .FIFO_ADDR_BASE(FB)) dut (.clk_in(clk_in),
    .resetn_in(resetn_in), .sck_in(sck), .csn_in(csn), .lane_in(lane), .lane_out(lane_out),
    .lane_oe_out(lane_oe), .req_valid_out(req_valid), .req_ready_in(req_ready), .req_out(req),
    .rdata_valid_in(rdata_valid), .rdata_in(rdata), .rdata_ready_out(rdata_ready),
    .lane_mode_out(lane_mode));
  sscf_host_model host (.dev_data_in(lane_out), .dev_oe_in(lane_oe), .sck_out(sck),
    .csn_out(csn), .lane_out(lane));
  function automatic logic [31:0] mem(input logic [15:0] a);
    return {a[13:0], 4'hC, ~a[13:0]};
  endfunction
  function automatic logic [15:0] step(input logic [15:0] a, input int k);
    if ((a & FM) == FB) return a;
    return a[15:14] == 2'h1 ? a + 16'(4 * k) : a[15:14] == 2'h2 ? a - 16'(4 * k) : a;
  endfunction
  function automatic logic [7:0] lanes(input int w);
    return 8'((16'h1 << w) - 16'h1);
  endfunction
  // Back end: takes requests, answers reads only while the frame is open
  always @(posedge clk_in) begin
    req_ready <= ~stall;
    if (csn || (rdata_valid && rdata_ready)) rdata_valid <= 1'b0;
    if (req_valid && req_ready) begin
      popped.push_back(req);
      if (!req.write && !csn) begin
        rdata <= mem(req.addr);
        rdata_valid <= 1'b1;
      end
    end
  end
  task automatic wrap_up();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Stalled words must wait in the buffer, then pop in order
  task automatic expect_req(input logic [15:0] a, input logic [31:0] d);
    int n = 0;
    if (stall) begin
      repeat (8) @(posedge clk_in);
      check("held valid", {31'h0, req_valid}, 32'h1);
      stall = 1'b0;
    end
    while (popped.size() == 0 && n < 400) begin
      @(posedge clk_in);
      n++;
    end
    if (popped.size() == 0) begin
      miscompares++;
      wrap_up();
    end
    check("req addr", {16'h0, popped[0].addr}, {16'h0, a});
    check("req write", {31'h0, popped[0].write}, 32'h1);
    check("req data", popped[0].data, d);
    void'(popped.pop_front());
  endtask
  // One frame: opcode, address, dummy, then words either way
  task automatic xfer(input logic [7:0] op, input int cw, input int aw, input int dw,
                      input int dmy, input logic [15:0] a, input int n);
    logic [7:0]  b;
    logic [31:0] got;
    logic [31:0] wd;
    host.begin_frame();
    host.shift_in({24'h0, op}, 8, cw, lanes(cw));
    if (aw > 0) host.shift_in({16'h0, a}, 16, aw, lanes(aw));
    if (dmy > 0) host.shift_in(32'h0, dmy * aw, aw, 8'hFF);
    for (int k = 0; k < n; k++) begin
      wd = 32'hA1B2C3D0 + 32'(k);
      for (int j = 0; j < 4; j++) begin
        if (dmy > 0) begin
          host.shift_out(b, dw);
          got[8 * j +: 8] = b;
        end else host.shift_in({24'h0, wd[8 * j +: 8]}, 8, dw, lanes(dw));
      end
      if (dmy > 0) check("read word", got, mem(step(a, k)));
    end
    host.end_frame();
    if (dmy > 0) begin
      repeat (16) @(posedge clk_in);
      check("read req", {15'h0, popped[0].write, popped[0].addr}, {16'h0, a});
      popped.delete();
    end else for (int k = 0; k < n; k++) expect_req(step(a, k), 32'hA1B2C3D0 + 32'(k));
  endtask
  task automatic mode_is(input sscf_pkg::sscf_lane_t m);
    repeat (6) @(posedge clk_in);
    check("lane mode", {30'h0, lane_mode}, {30'h0, m});
  endtask
  // Every single-lane read and write variant, one word each
  task automatic t_variants();
    logic [7:0] rd[5] = '{`SSCF_OP_READ, `SSCF_OP_DOREAD2, `SSCF_OP_IOREAD2,
                          `SSCF_OP_DOREAD4, `SSCF_OP_IOREAD4};
    logic [7:0] wr[5] = '{`SSCF_OP_WRITE, `SSCF_OP_DWRITE2, `SSCF_OP_AWRITE2,
                          `SSCF_OP_DWRITE4, `SSCF_OP_AWRITE4};
    int aw[5] = '{1, 1, 2, 1, 4};
    int dw[5] = '{1, 2, 2, 4, 4};
    for (int i = 0; i < 5; i++) begin
      xfer(rd[i], 1, aw[i], dw[i], 8, 16'h0104 + 16'(i * 8), 1);
      xfer(wr[i], 1, aw[i], dw[i], 0, 16'h0204 + 16'(i * 8), 1);
    end
  endtask
  // Stalled writes, stepping reads, FIFO region without stepping
  task automatic t_bursts();
    stall = 1'b1;
    xfer(`SSCF_OP_WRITE, 1, 1, 1, 0, 16'h4010, 2);
    xfer(`SSCF_OP_READ, 1, 1, 1, 8, 16'h8020, 3);
    xfer(`SSCF_OP_READ, 1, 1, 1, 8, 16'h0024, 2);
    xfer(`SSCF_OP_AWRITE4, 1, 4, 4, 0, 16'h7000, 2);
    xfer(`SSCF_OP_IOREAD2, 1, 2, 2, 8, 16'hB000, 2);
  endtask
  // Quad and octal modes: entry, traffic, exit
  task automatic t_modes();
    xfer(`SSCF_OP_ENTER_QUAD, 1, 0, 0, 0, 16'h0, 0);
    mode_is(sscf_pkg::SSCF_LANE_QUAD);
    xfer(`SSCF_OP_READ, 4, 4, 4, 6, 16'h4100, 2);
    xfer(`SSCF_OP_WRITE, 4, 4, 4, 0, 16'h8100, 2);
    xfer(`SSCF_OP_EXIT_WIDE, 4, 0, 0, 0, 16'h0, 0);
    mode_is(sscf_pkg::SSCF_LANE_SINGLE);
    xfer(`SSCF_OP_ENTER_OCT, 1, 0, 0, 0, 16'h0, 0);
    mode_is(sscf_pkg::SSCF_LANE_OCT);
    xfer(`SSCF_OP_READ, 8, 8, 8, 8, 16'h4200, 2);
    xfer(`SSCF_OP_WRITE, 8, 8, 8, 0, 16'h0300, 1);
    xfer(`SSCF_OP_EXIT_WIDE, 8, 0, 0, 0, 16'h0, 0);
    mode_is(sscf_pkg::SSCF_LANE_SINGLE);
  endtask
  // Quad write cut after three data bytes, then activity with select high
  task automatic t_abort();
    xfer(`SSCF_OP_ENTER_QUAD, 1, 0, 0, 0, 16'h0, 0);
    host.begin_frame();
    host.shift_in({24'h0, `SSCF_OP_WRITE}, 8, 4, 8'h0F);
    host.shift_in(32'h4400, 16, 4, 8'h0F);
    host.shift_in(32'h123456, 24, 4, 8'h0F);
    host.end_frame();
    host.noise(16);
    mode_is(sscf_pkg::SSCF_LANE_QUAD);
    xfer(`SSCF_OP_WRITE, 4, 4, 4, 0, 16'h0440, 1);
    check("extra requests", 32'(popped.size()), 32'h0);
    xfer(`SSCF_OP_EXIT_WIDE, 4, 0, 0, 0, 16'h0, 0);
    mode_is(sscf_pkg::SSCF_LANE_SINGLE);
  endtask
  task automatic t_idle_high();
    host.cpol = 1'b1;
    xfer(`SSCF_OP_WRITE, 1, 1, 1, 0, 16'h4400, 2);
    xfer(`SSCF_OP_DOREAD2, 1, 1, 2, 8, 16'h4400, 2);
    host.cpol = 1'b0;
  endtask
  initial begin
    repeat (2) @(posedge clk_in);
    resetn_in <= 1'b1;
    repeat (4) @(posedge clk_in);
    t_variants();
    t_bursts();
    t_modes();
    t_abort();
    t_idle_high();
    check("lane clash", 32'(host.clash), 32'h0);
    wrap_up();
  end
  // Hang guard
  initial begin
    #2000000;
    miscompares++;
    wrap_up();
  end
endmodule
`default_nettype wire
